// [design/emb_pkg.sv]
/*
 Constants, modes and carriers shared by the embedded memory block.
 Assumes one clock and a plain register port.
*/
package emb_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 6;
   localparam int DEPTH   = 64;
   localparam int N_MACRO = 16;
   localparam int N_FB    = 9;
   localparam int N_IN    = 32;
   localparam int REG_AW  = 8;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFS      = 8'h00;
   localparam logic [7:0]  STATUS_OFS    = 8'h04;
   localparam logic [7:0]  LOAD_ADDR_OFS = 8'h08;
   localparam logic [7:0]  LOAD_DATA_OFS = 8'h0c;
   localparam int          MODE_LSB      = 0;
   localparam int          LOWPWR_BIT    = 4;
   localparam int          OUTREG_BIT    = 5;
   localparam int          BYPASS_LSB    = 16;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [5:0]  LOAD_ADDR_RST = 6'h00;

   // Operating modes; codes above MODE_PTERM act as off
   typedef enum logic [2:0] {
      MODE_OFF, MODE_RAM, MODE_ROM, MODE_FIFO, MODE_CAM, MODE_PTERM
   } mode_t;

   // Input-side request captured by the input registers
   typedef struct packed {
      logic              wr_en;
      logic              rd_en;
      logic [ADDR_W-1:0] wr_addr;
      logic [ADDR_W-1:0] rd_addr;
      logic [DATA_W-1:0] wr_data;
   } in_req_t;
endpackage

// [design/embedded_memory_block.sv]
/*
 Embedded memory block: RAM, ROM, FIFO, content addressable memory
 and product-term macrocells behind one register port.
 Assumes user fabric logic on sys_clk_i drives the requests.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module embedded_memory_block (
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_i,
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [31:0]              reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output logic      [31:0]              reg_rdata_o,
   input  wire logic                     in_ce_i,
   input  wire logic                     out_ce_i,
   input  wire logic                     local_in_clr_i,
   input  wire logic                     local_out_clr_i,
   input  wire logic                     global_clr_i,
   input  wire logic                     chip_clr_i,
   input  wire emb_pkg::in_req_t         req_i,
   input  wire logic [31:0]              fabric_i,
   output logic      [31:0]              rd_data_o,
   output logic                          fifo_full_o,
   output logic                          fifo_empty_o,
   output logic                          cam_hit_o,
   output logic      [5:0]               cam_addr_o,
   output logic      [15:0]              macro_o,
   output logic      [8:0]               macro_fb_o,
   output logic                          power_down_o
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // One product term: AND of masked inputs, empty mask gives zero
   function automatic logic pterm(input logic [31:0] mask,
                                  input logic [31:0] in);
      pterm = (mask != 32'h0000_0000) && (&(in | ~mask));
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [31:0]           ctrl;
   logic [5:0]            load_addr;
   logic [31:0]           mem [0:emb_pkg::DEPTH-1];
   emb_pkg::in_req_t      req_q;
   emb_pkg::in_req_t      next_req;
   logic [6:0]            wptr;
   logic [6:0]            rptr;
   logic [63:0]           cam_vld;
   logic [31:0]           lp_q;
   logic [31:0]           pipe_q;
   logic [15:0]           mc_q;
   logic [15:0]           pt_sum;
   logic                  cam_hit_c;
   logic [5:0]            cam_addr_c;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Clear sources merged per side
   wire in_clr  = local_in_clr_i | global_clr_i | chip_clr_i;
   wire out_clr = local_out_clr_i | global_clr_i | chip_clr_i;
   wire [2:0] mode_raw = ctrl[emb_pkg::MODE_LSB +: 3];
   wire emb_pkg::mode_t mode = (mode_raw > 3'h5) ? emb_pkg::MODE_OFF
                               : emb_pkg::mode_t'(mode_raw);
   wire is_off   = (mode == emb_pkg::MODE_OFF);
   wire is_ram   = (mode == emb_pkg::MODE_RAM);
   wire is_rom   = (mode == emb_pkg::MODE_ROM);
   wire is_fifo  = (mode == emb_pkg::MODE_FIFO);
   wire is_cam   = (mode == emb_pkg::MODE_CAM);
   wire is_pterm = (mode == emb_pkg::MODE_PTERM);
   wire low_pwr  = ctrl[emb_pkg::LOWPWR_BIT];
   wire out_reg  = ctrl[emb_pkg::OUTREG_BIT];
   wire [15:0] bypass = ctrl[emb_pkg::BYPASS_LSB +: 16];

   // Register port decode
   wire wr_ctrl  = reg_wr_i && (reg_addr_i == emb_pkg::CTRL_OFS);
   wire wr_laddr = reg_wr_i && (reg_addr_i == emb_pkg::LOAD_ADDR_OFS);
   wire wr_ldata = reg_wr_i && (reg_addr_i == emb_pkg::LOAD_DATA_OFS);
   wire [31:0] status = {16'h0000, power_down_o, cam_hit_o, fifo_full_o,
                         fifo_empty_o, 1'b0, rptr, 4'h0};
   wire [31:0] next_rdata =
      !reg_rd_i                            ? 32'h0000_0000 :
      (reg_addr_i == emb_pkg::CTRL_OFS)      ? ctrl :
      (reg_addr_i == emb_pkg::STATUS_OFS)    ? status :
      (reg_addr_i == emb_pkg::LOAD_ADDR_OFS) ? {26'h0, load_addr} :
                                               32'h0000_0000;

   // Input request: strobes only live while the input side is enabled
   always_comb begin
      next_req = req_q;
      next_req.wr_en = 1'b0;
      next_req.rd_en = 1'b0;
      if (in_ce_i && !is_off) begin
         next_req = req_i;
      end
   end

   // FIFO occupancy and accepted transfers
   wire [6:0] fill  = 7'(wptr - rptr);
   wire push        = is_fifo && req_q.wr_en && !fifo_full_o;
   wire pop         = is_fifo && req_q.rd_en && !fifo_empty_o;
   wire [6:0] next_wptr = 7'(wptr + {6'h00, push});
   wire [6:0] next_rptr = 7'(rptr + {6'h00, pop});
   wire [6:0] next_fill = 7'(next_wptr - next_rptr);
   wire fab_wr = (is_ram || is_cam) && req_q.wr_en;
   wire rd_fire = ((is_ram || is_rom) && req_q.rd_en) || pop;
   wire [5:0] rd_idx = is_fifo ? rptr[5:0] : req_q.rd_addr;
   wire [31:0] rd_word = mem[rd_idx];

   // Output stages: low power adds one stage, out_reg a second one
   wire [31:0] src = low_pwr ? lp_q : rd_word;
   wire [31:0] next_out = out_reg ? pipe_q : src;
   // Macrocell output: bypassed sum or registered sum per cell
   wire [15:0] macro_next = (bypass & pt_sum) | (~bypass & mc_q);

   // Content search on the captured write data
   always_comb begin
      cam_hit_c  = 1'b0;
      cam_addr_c = 6'h00;
      for (int i = emb_pkg::DEPTH - 1; i >= 0; i--) begin
         if (cam_vld[i] && (mem[i] == req_q.wr_data)) begin
            cam_hit_c  = 1'b1;
            cam_addr_c = 6'(i);
         end
      end
   end

   // Macrocell sums from word pairs holding term masks
   always_comb begin
      for (int m = 0; m < emb_pkg::N_MACRO; m++) begin
         pt_sum[m] = pterm(mem[2*m], fabric_i)
                   | pterm(mem[2*m+1], fabric_i);
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Control, load pointer and register read data
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl        <= emb_pkg::CTRL_RST;
         load_addr   <= emb_pkg::LOAD_ADDR_RST;
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl <= reg_wdata_i;
         if (wr_laddr) load_addr <= reg_wdata_i[5:0];
         else if (wr_ldata) load_addr <= 6'(load_addr + 6'h01);
         reg_rdata_o <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Pattern load wins over fabric writes; ROM and PTERM ignore fabric
   always_ff @(posedge sys_clk_i) begin
      if (wr_ldata) mem[load_addr] <= reg_wdata_i;
      else if (fab_wr) mem[req_q.wr_addr] <= req_q.wr_data;
      else if (push) mem[wptr[5:0]] <= req_q.wr_data;
   end

   // ---------------------------------------------------------------
   // Input-side registers
   // ---------------------------------------------------------------
   // Request capture, FIFO pointers and CONTENT_ADDRESSABLE_MEMORY valid bits
   always_ff @(posedge sys_clk_i or posedge in_clr) begin
      if (in_clr) begin
         req_q        <= '0;
         wptr         <= 7'h00;
         rptr         <= 7'h00;
         fifo_full_o  <= 1'b0;
         fifo_empty_o <= 1'b1;
         cam_vld      <= 64'h0;
         mc_q         <= 16'h0000;
      end else if (rst_i || is_off) begin
         req_q        <= '0;
         wptr         <= 7'h00;
         rptr         <= 7'h00;
         fifo_full_o  <= 1'b0;
         fifo_empty_o <= 1'b1;
         cam_vld      <= 64'h0;
         mc_q         <= 16'h0000;
      end else begin
         req_q        <= next_req;
         wptr         <= next_wptr;
         rptr         <= next_rptr;
         fifo_full_o  <= (next_fill == 7'h40);
         fifo_empty_o <= (next_fill == 7'h00);
         if (is_cam && req_q.wr_en) cam_vld[req_q.wr_addr] <= 1'b1;
         mc_q         <= is_pterm ? pt_sum : 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Output-side registers
   // ---------------------------------------------------------------
   // Read data, search result and macrocell outputs
   always_ff @(posedge sys_clk_i or posedge out_clr) begin
      if (out_clr) begin
         lp_q       <= 32'h0;
         pipe_q     <= 32'h0;
         rd_data_o  <= 32'h0;
         cam_hit_o  <= 1'b0;
         cam_addr_o <= 6'h00;
         macro_o    <= 16'h0000;
         macro_fb_o <= 9'h000;
      end else if (rst_i || is_off) begin
         lp_q       <= 32'h0;
         pipe_q     <= 32'h0;
         rd_data_o  <= 32'h0;
         cam_hit_o  <= 1'b0;
         cam_addr_o <= 6'h00;
         macro_o    <= 16'h0000;
         macro_fb_o <= 9'h000;
      end else if (out_ce_i) begin
         if (rd_fire) lp_q <= rd_word;
         pipe_q     <= src;
         rd_data_o  <= next_out;
         if (is_cam && req_q.rd_en) begin
            cam_hit_o  <= cam_hit_c;
            cam_addr_o <= cam_addr_c;
         end
         macro_o    <= macro_next;
         macro_fb_o <= macro_next[8:0];
      end
   end

   // Power state follows the mode
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) power_down_o <= 1'b1;
      else power_down_o <= is_off;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   wire [31:0] probe_word = mem[req_q.wr_addr];
   wire quiet = !in_clr && !out_clr;

   property p_in_capture;
      quiet && in_ce_i && !is_off && req_i.wr_en |=> req_q.wr_en;
   endproperty
   a_in_capture: assert property (p_in_capture)
      else $error("write strobe not captured");

   property p_in_gate;
      quiet && !in_ce_i |=> !req_q.wr_en && !req_q.rd_en;
   endproperty
   a_in_gate: assert property (p_in_gate)
      else $error("strobe passed with input side disabled");

   property p_out_hold;
      quiet && !out_ce_i ##1 !out_clr |-> $stable(rd_data_o);
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("read data moved with output side disabled");

   property p_clear;
      out_clr |-> rd_data_o == 32'h0 && macro_o == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("output registers not cleared");

   property p_off;
      is_off |=> power_down_o && rd_data_o == 32'h0;
   endproperty
   a_off: assert property (p_off)
      else $error("unused block not powered down");

   property p_rom_fixed;
      quiet && is_rom && req_q.wr_en && !wr_ldata
         |=> mem[$past(req_q.wr_addr)] == $past(probe_word);
   endproperty
   a_rom_fixed: assert property (p_rom_fixed)
      else $error("fabric write altered lookup contents");

   property p_low_pwr;
      quiet && is_ram && low_pwr && !out_reg && rd_fire && out_ce_i && !wr_ctrl
         ##1 quiet && out_ce_i
         |=> rd_data_o == $past(rd_word, 2);
   endproperty
   a_low_pwr: assert property (p_low_pwr)
      else $error("low power read not two cycles late");

   property p_fast_rd;
      quiet && is_ram && !low_pwr && !out_reg && rd_fire && out_ce_i
         |=> rd_data_o == $past(rd_word);
   endproperty
   a_fast_rd: assert property (p_fast_rd)
      else $error("fast read data wrong");

   property p_fb;
      macro_fb_o == macro_o[8:0];
   endproperty
   a_fb: assert property (p_fb)
      else $error("feedback differs from macrocells");

   property p_fifo_flags;
      !(fifo_full_o && fifo_empty_o);
   endproperty
   a_fifo_flags: assert property (p_fifo_flags)
      else $error("FIFO full and empty together");

   c_rw_same: cover property (is_ram && req_q.wr_en && req_q.rd_en);
   c_fifo_full: cover property (is_fifo && fifo_full_o);
   c_cam_hit: cover property (is_cam && cam_hit_o);
   c_pterm: cover property (is_pterm && macro_o != 16'h0000);
endmodule

`default_nettype wire

// [test/fabric_user.sv]
/*
 Model of the user logic in the fabric around the memory block.
 Assumes the bench calls its tasks and that it shares sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module fabric_user (
   input  wire logic             sys_clk_i,
   output var emb_pkg::in_req_t  req_o,
   output logic [31:0]           fabric_o
);
   // Idle outputs at time zero
   initial begin
      req_o    = '0;
      fabric_o = 32'h0;
   end

   // One-cycle request; read and write may share it
   task automatic issue(input logic we, input logic re, input logic [5:0] wa,
                        input logic [5:0] ra, input logic [31:0] wd);
      @(posedge sys_clk_i);
      req_o <= '{we, re, wa, ra, wd};
      @(posedge sys_clk_i);
      req_o <= '{1'b0, 1'b0, ~wa, ~ra, ~wd};
   endtask

   // Product-term inputs, held until the next call
   task automatic drive(input logic [31:0] val);
      @(posedge sys_clk_i);
      fabric_o <= val;
   endtask
endmodule
`default_nettype wire

// [test/embedded_memory_block_test.sv]
/*
 Self-checking bench for the embedded memory block.
 Assumes the fabric model drives requests and product-term inputs; the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module embedded_memory_block_test;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   typedef struct {int due; int kind; logic [31:0] val;} note_t;
   logic             sys_clk = 1'b0;
   logic             rst = 1'b1;
   logic [7:0]       reg_addr = 8'h00;
   logic [31:0]      reg_wdata = 32'h0;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic             in_ce = 1'b1;
   logic             out_ce = 1'b1;
   logic [3:0]       clr = 4'h0;
   emb_pkg::in_req_t req;
   logic [31:0]      fabric, reg_rdata, rd_data, seen, v, d;
   logic             full, empty, cam_hit, power_down;
   logic [5:0]       cam_addr, a;
   logic [15:0]      macro;
   logic [8:0]       macro_fb;
   logic [31:0]      mem_m [64];
   note_t            exp_q [$];
   note_t            e;
   int               cyc = 0, tick = 0, lat = 2, err_count = 0, tests_run = 0;
   int               seed = 22804;

   always #4 sys_clk = ~sys_clk;

   embedded_memory_block embedded_memory_block_i (
      .sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .in_ce_i(in_ce), .out_ce_i(out_ce),
      .local_in_clr_i(clr[0]), .local_out_clr_i(clr[1]), .global_clr_i(clr[2]),
      .chip_clr_i(clr[3]), .req_i(req), .fabric_i(fabric), .rd_data_o(rd_data),
      .fifo_full_o(full), .fifo_empty_o(empty), .cam_hit_o(cam_hit),
      .cam_addr_o(cam_addr), .macro_o(macro), .macro_fb_o(macro_fb),
      .power_down_o(power_down));

   fabric_user fabric_user_i (.sys_clk_i(sys_clk), .req_o(req), .fabric_o(fabric));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] ev);
      tests_run++;
      if (got !== ev) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, got, ev);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic note(input int due, input int kind, input logic [31:0] val);
      exp_q.push_back('{due, kind, val});
   endtask

   task automatic drain();
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      @(posedge sys_clk);
      reg_addr  <= ad;
      reg_wdata <= dt;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [31:0] ev);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      note(cyc + 1, 0, ev);
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
   endtask

   task automatic fab(input logic we, input logic re, input logic [5:0] wa,
                      input logic [5:0] ra, input logic [31:0] wd, input int kind,
                      input logic [31:0] ev);
      fabric_user_i.issue(we, re, wa, ra, wd);
      if (re) note(cyc - 1 + lat, kind, ev);
   endtask

   // Clear pulse: read data or fifo state must drop at once
   task automatic clr_hit(input int i);
      @(posedge sys_clk);
      clr[i] <= 1'b1;
      #1;
      check(i == 0 ? {31'h0, empty} : rd_data, i == 0 ? 32'h1 : 32'h0);
      @(posedge sys_clk);
      clr[i] <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Monitor and timeout
   // ------------------------------------------------------------
   always @(negedge sys_clk) begin
      while (exp_q.size() > 0 && exp_q[0].due <= cyc) begin
         e = exp_q.pop_front();
         case (e.kind)
            0: seen = reg_rdata;
            1: seen = rd_data;
            2: seen = {16'h0, macro};
            3: seen = {23'h0, macro_fb};
            default: seen = {25'h0, cam_hit, cam_addr};
         endcase
         check(seen, e.val);
      end
      cyc++;
   end

   always @(posedge sys_clk) begin
      tick++;
      if (tick == 6000) begin
         err_count++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      check({31'h0, power_down}, 32'h1);
      check({31'h0, empty}, 32'h1);
      rd(emb_pkg::CTRL_OFS, emb_pkg::CTRL_RST);
      rd(8'h10, 32'h0);
      wr(emb_pkg::LOAD_ADDR_OFS, 32'h0);
      for (int i = 0; i < 64; i++) begin
         mem_m[i] = $random(seed);
         wr(emb_pkg::LOAD_DATA_OFS, mem_m[i]);
      end
      // Lookup through the loaded pattern; writes refused
      wr(emb_pkg::CTRL_OFS, 32'h2);
      fab(1'b1, 1'b0, 6'h07, 6'h0, ~mem_m[7], 1, 0);
      for (int i = 0; i < 8; i++) fab(1'b0, 1'b1, 6'h0, 6'(i * 7), 0, 1, mem_m[i * 7]);
      drain();
      // Dual-port use under each speed and pipeline setting
      for (int c = 0; c < 4; c++) begin
         wr(emb_pkg::CTRL_OFS, 32'h1 | (32'(c) << 4));
         lat = 2 + (c & 1) + (c >> 1);
         for (int k = 0; k < 3; k++) begin
            a = 6'($random(seed));
            d = $random(seed);
            fab(1'b1, 1'b1, a, a, d, 1, mem_m[a]);
            mem_m[a] = d;
            fab(1'b0, 1'b1, 6'h0, a, 0, 1, d);
         end
         drain();
      end
      wr(emb_pkg::CTRL_OFS, 32'h1);
      lat = 2;
      a = 6'h09;
      @(posedge sys_clk);
      in_ce <= 1'b0;
      fab(1'b1, 1'b0, a, 6'h0, ~mem_m[a], 1, 0);
      in_ce <= 1'b1;
      fab(1'b0, 1'b1, 6'h0, a, 0, 1, mem_m[a]);
      drain();
      @(posedge sys_clk);
      out_ce <= 1'b0;
      // Output froze on the word of the idle read address
      fab(1'b0, 1'b1, 6'h0, 6'h0b, 0, 1, mem_m[~a]);
      drain();
      out_ce <= 1'b1;
      for (int i = 1; i < 4; i++) begin
         fab(1'b0, 1'b1, 6'h0, 6'(i), 0, 1, mem_m[i]);
         drain();
         clr_hit(i);
      end
      // Queue use, then the input-side clear
      wr(emb_pkg::CTRL_OFS, 32'h3);
      d = $random(seed);
      fab(1'b1, 1'b0, 6'h0, 6'h0, d, 1, 0);
      fab(1'b1, 1'b0, 6'h0, 6'h0, ~d, 1, 0);
      fab(1'b0, 1'b1, 6'h0, 6'h0, 0, 1, d);
      drain();
      check({31'h0, empty}, 32'h0);
      // Fill to the brim: one held entry plus 63 pushes
      for (int i = 0; i < 63; i++) fab(1'b1, 1'b0, 6'h0, 6'h0, 32'(i), 1, 0);
      @(posedge sys_clk);
      #1;
      check({31'h0, full}, 32'h1);
      clr_hit(0);
      // Associative search
      wr(emb_pkg::CTRL_OFS, 32'h4);
      d = $random(seed);
      fab(1'b1, 1'b0, 6'h07, 6'h0, d, 4, 0);
      fab(1'b0, 1'b1, 6'h0, 6'h0, d, 4, 32'h47);
      drain();
      // Macrocells: even words mask one fabric bit, odd words empty
      wr(emb_pkg::LOAD_ADDR_OFS, 32'h0);
      for (int i = 0; i < 32; i++) wr(emb_pkg::LOAD_DATA_OFS, i[0] ? 0 : 32'h1 << (i / 2));
      wr(emb_pkg::CTRL_OFS, 32'hffff_0005);
      for (int k = 0; k < 6; k++) begin
         v = $random(seed);
         fabric_user_i.drive(v);
         note(cyc + 2, 2, {16'h0, v[15:0]});
         note(cyc + 2, 3, {23'h0, v[8:0]});
         repeat (2) @(posedge sys_clk);
      end
      wr(emb_pkg::CTRL_OFS, 32'h0000_0005);
      d = $random(seed);
      fabric_user_i.drive(d);
      note(cyc + 1, 2, {16'h0, v[15:0]});
      note(cyc + 2, 2, {16'h0, d[15:0]});
      drain();
      // Every mode code, with power-down for the unused ones
      for (int m = 0; m < 8; m++) begin
         wr(emb_pkg::CTRL_OFS, 32'(m));
         @(posedge sys_clk);
         #1;
         check({31'h0, power_down}, (m == 0 || m > 5) ? 32'h1 : 32'h0);
      end
      rd(emb_pkg::STATUS_OFS, 32'h0000_9000);
      drain();
      print_verdict();
   end
endmodule
`default_nettype wire
